//--- include/srp_pkg.sv
// shared constants for the refresh and power command block
package srp_pkg;
  // command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  // cas latency codes
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  // field positions and sizes
  localparam int AP_BIT = 10;
  localparam int FULL_PAGE_WORDS = 512;
  localparam int CNT_W = 8;
  // timing
  localparam int MCLK_PERIOD_NS = 40;
  localparam int TRC_NS = 60;
  localparam int TXSR_NS = 70;
  localparam int RET_MS = 64;
  localparam int REF_COUNT = 8192;
  localparam int TRC_CYC = (TRC_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int TXSR_CYC = (TXSR_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SREF_CYC = (RET_MS * 1000000 / REF_COUNT) / MCLK_PERIOD_NS;
  // reset values
  localparam logic [12:0] REF_ROW_RST = 13'h0000;
  localparam logic [3:0] BANKS_RST = 4'h0;
  // top-level states
  typedef enum logic [2:0] {ST_RUN, ST_REF, ST_PDN, ST_SELF, ST_SXIT} srp_state_t;
endpackage

//--- verilog/srp_fifo.sv
// write data buffer between the pins and the bank array
`timescale 1ns/1ps
module srp_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] DEPTH_C = (PTR_W + 1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic [PTR_W:0] count_d;
  logic in_ready_q;
  logic out_valid_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready_q;
  assign pop = out_ready && out_valid_q;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_inc(rd_ptr_q);
      end
      count_q <= count_d;
      in_ready_q <= (count_d != DEPTH_C);
      out_valid_q <= (count_d != '0);
    end
  end
endmodule // srp_fifo

//--- verilog/srp_sdram_cmd.sv
// sdram command engine for burst stop, refresh, suspend and power-down
// Notes on behaviour
// RULE1 - burst stop ends bursts without auto precharge
// RULE2 - stopped read drains for cas latency cycles
// RULE3 - deselect ignores strobes and address inputs
// RULE4 - auto refresh code, address ignored
// RULE5 - internal row counter advances per refresh
// RULE6 - controller refreshes enough within retention time
// RULE7 - controller refreshes only idle, not powered down
// RULE8 - controller sends nops until refresh completes
// RULE9 - controller waits precharge time between refreshes
// RULE10 - self refresh entry is refresh, clock disabled
// RULE11 - self refresh ignores all but clock enable
// RULE12 - controller restarts clock, then raises enable
// RULE13 - controller idles for exit time after self refresh
// RULE14 - full refresh burst around self refresh advised
// RULE15 - clock enable low in burst freezes state
// RULE16 - clock enable low when idle powers down
// RULE17 - controller limits suspend and power-down time
// RULE18 - clock enable high restarts next cycle
// RULE19 - power-down exit reenables buffers, one cycle gap
// RULE20 - mask high blocks writing that word
// RULE21 - mask high floats outputs during read
// RULE22 - nop registers no command
// RULE23 - burst stop code is ras high cas high we low
// RULE24 - stopped write writes nothing from stop cycle
`timescale 1ns/1ps
module srp_sdram_cmd
  import srp_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ROW_W = 13,
  parameter int COL_W = 9,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic dqm,
  input wire logic [1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  // data pin
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // mode settings
  input wire logic [2:0] cas_lat,
  input wire logic [2:0] burst_len,
  // bank array read
  output logic arr_rd_en,
  output logic [1:0] arr_rd_bank,
  output logic [COL_W-1:0] arr_rd_col,
  input wire logic [DATA_W-1:0] arr_rd_data,
  // bank array write
  output logic arr_wr_valid,
  input wire logic arr_wr_ready,
  output logic [1:0] arr_wr_bank,
  output logic [COL_W-1:0] arr_wr_col,
  output logic [DATA_W-1:0] arr_wr_data,
  // bank array refresh
  output logic ref_stb,
  output logic [ROW_W-1:0] ref_row,
  // status
  output logic wbuf_ready,
  output logic self_ref,
  output logic power_down
);
  localparam int WW = 2 + COL_W + DATA_W;

  srp_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] tmr_q;
  logic cke_q;
  logic [3:0] bank_open_q;
  logic burst_q, bwr_q, bap_q, bfull_q;
  logic [1:0] bbank_q;
  logic [COL_W-1:0] bcol_q;
  logic [9:0] bleft_q;
  logic rd_en_q;
  logic [1:0] rd_bank_q;
  logic [COL_W-1:0] rd_col_q;
  logic p1_v_q, p2_v_q;
  logic [DATA_W-1:0] p1_d_q, p2_d_q, dq_out_q;
  logic dq_oe_q;
  logic ref_stb_q;
  logic [ROW_W-1:0] ref_row_q;
  logic self_ref_q, power_down_q;
  logic run, cmd_ok, all_idle, sref_tick;
  logic [2:0] cmd;
  logic is_rd, is_wr, is_rdwr, is_act, is_pre, is_ref, is_sre, is_bst, pd_enter;
  logic advance, wr_push, burst_end;
  logic [WW-1:0] wr_word, fifo_out;
  logic [1:0] wr_bank;
  logic [COL_W-1:0] wr_col;

  function automatic logic [9:0] len_words(input logic [2:0] code);
    case (code)
      BL_1: len_words = 10'h001;
      BL_2: len_words = 10'h002;
      BL_4: len_words = 10'h004;
      BL_8: len_words = 10'h008;
      default: len_words = 10'(FULL_PAGE_WORDS);
    endcase
  endfunction

  // sequential wrap inside the burst window
  function automatic logic [COL_W-1:0] col_next(input logic [COL_W-1:0] c, input logic [2:0] code);
    logic [COL_W-1:0] m;
    m = COL_W'(len_words(code) - 10'h001);
    col_next = (c & ~m) | ((c + 1'b1) & m);
  endfunction

  // RULE18 RULE15 masked internal clock
  assign run = cke_q;
  assign cmd = {ras_n, cas_n, we_n};
  // RULE3 deselect blocks decode
  assign cmd_ok = (st_q == ST_RUN) && run && !cs_n;
  assign all_idle = (bank_open_q == 4'h0);
  assign is_rd = cmd_ok && (cmd == CMD_READ);
  assign is_wr = cmd_ok && (cmd == CMD_WRITE);
  assign is_rdwr = is_rd || is_wr;
  assign is_act = cmd_ok && (cmd == CMD_ACT);
  assign is_pre = cmd_ok && (cmd == CMD_PRE);
  // RULE4 refresh decode, address unused
  assign is_ref = cmd_ok && (cmd == CMD_REF) && cke && all_idle && !burst_q;
  // RULE10 self refresh decode
  assign is_sre = cmd_ok && (cmd == CMD_REF) && !cke && all_idle && !burst_q;
  // RULE23 RULE1 stop decode, auto precharge exempt
  assign is_bst = cmd_ok && (cmd == CMD_BST) && burst_q && !bap_q;
  // RULE16 idle enable low
  assign pd_enter = (st_q == ST_RUN) && run && !cke && all_idle && !burst_q && !is_sre
                    && !is_rdwr && !is_act;
  // RULE22 any command but read, write or burst stop lets the burst run on
  assign advance = (st_q == ST_RUN) && run && burst_q && !is_rdwr && !is_bst;
  assign burst_end = advance && (bleft_q == 10'h001) && !bfull_q;
  assign sref_tick = (st_q == ST_SELF) && (tmr_q == CNT_W'(SREF_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_RUN: begin
        if (is_ref) begin
          st_d = ST_REF;
          cnt_d = CNT_W'(TRC_CYC - 1);
        end else if (is_sre) begin
          st_d = ST_SELF;
        end else if (pd_enter) begin
          st_d = ST_PDN;
        end
      end
      ST_REF: begin
        if (cnt_q <= CNT_W'(1)) begin
          st_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      // RULE19 exit on enable high
      ST_PDN: begin
        if (cke) begin
          st_d = ST_RUN;
        end
      end
      // RULE11 only enable is watched
      ST_SELF: begin
        if (cke) begin
          st_d = ST_SXIT;
          cnt_d = CNT_W'(TXSR_CYC - 1);
        end
      end
      ST_SXIT: begin
        if (cnt_q <= CNT_W'(1)) begin
          st_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ST_RUN;
      cnt_q <= '0;
      self_ref_q <= 1'b0;
      power_down_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      self_ref_q <= (st_d == ST_SELF);
      power_down_q <= (st_d == ST_PDN);
    end
  end

  // RULE11 internal refresh timer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (st_q != ST_SELF || sref_tick) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // RULE5 row counter advances once per refresh
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ref_stb_q <= 1'b0;
      ref_row_q <= ROW_W'(REF_ROW_RST);
    end else begin
      ref_stb_q <= is_ref || is_sre || sref_tick;
      if (is_ref || is_sre || sref_tick) begin
        ref_row_q <= ref_row_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bank_open_q <= BANKS_RST;
    end else if (is_act) begin
      bank_open_q[ba] <= 1'b1;
    end else if (is_pre) begin
      if (addr[AP_BIT]) begin
        bank_open_q <= 4'h0;
      end else begin
        bank_open_q[ba] <= 1'b0;
      end
    end else if (burst_end && bap_q) begin
      bank_open_q[bbank_q] <= 1'b0;
    end
  end

  // RULE15 burst state frozen while suspended
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      burst_q <= 1'b0;
      bwr_q <= 1'b0;
      bap_q <= 1'b0;
      bfull_q <= 1'b0;
      bbank_q <= 2'h0;
      bcol_q <= '0;
      bleft_q <= 10'h000;
    end else if (is_rdwr) begin
      burst_q <= (burst_len != BL_1);
      bwr_q <= is_wr;
      bap_q <= addr[AP_BIT];
      bfull_q <= (burst_len == BL_FULL);
      bbank_q <= ba;
      bcol_q <= col_next(addr[COL_W-1:0], burst_len);
      bleft_q <= len_words(burst_len) - 10'h001;
    end else if (is_bst) begin
      // RULE1 stop ends the burst
      burst_q <= 1'b0;
    end else if (advance) begin
      bcol_q <= col_next(bcol_q, burst_len);
      bleft_q <= bleft_q - 10'h001;
      if (burst_end) begin
        burst_q <= 1'b0;
      end
    end
  end

  // array fetch for read bursts
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_en_q <= 1'b0;
      rd_bank_q <= 2'h0;
      rd_col_q <= '0;
    end else if (is_rd) begin
      rd_en_q <= 1'b1;
      rd_bank_q <= ba;
      rd_col_q <= addr[COL_W-1:0];
    end else if (advance && !bwr_q) begin
      rd_en_q <= 1'b1;
      rd_col_q <= bcol_q;
    end else if ((st_q == ST_RUN) && run) begin
      rd_en_q <= 1'b0;
    end
  end

  // RULE2 fetched words still drain through the latency pipe
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      p1_v_q <= 1'b0;
      p2_v_q <= 1'b0;
      p1_d_q <= '0;
      p2_d_q <= '0;
      dq_out_q <= '0;
      dq_oe_q <= 1'b0;
    end else if (st_q != ST_RUN) begin
      p1_v_q <= 1'b0;
      p2_v_q <= 1'b0;
      dq_oe_q <= 1'b0;
    end else if (run) begin
      p1_v_q <= rd_en_q;
      p1_d_q <= arr_rd_data;
      p2_v_q <= p1_v_q;
      p2_d_q <= p1_d_q;
      dq_out_q <= (cas_lat == CL_3) ? p2_d_q : p1_d_q;
      // RULE21 mask high floats the outputs
      dq_oe_q <= ((cas_lat == CL_3) ? p2_v_q : p1_v_q) && !dqm;
    end
  end

  // RULE20 RULE24 masked words and the stop cycle write nothing
  assign wr_push = (is_wr || (advance && bwr_q)) && !dqm;
  assign wr_bank = is_wr ? ba : bbank_q;
  assign wr_col = is_wr ? addr[COL_W-1:0] : bcol_q;
  assign wr_word = {wr_bank, wr_col, dq_in};

  srp_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(wr_push),
    .in_ready(wbuf_ready),
    .in_data(wr_word),
    .out_valid(arr_wr_valid),
    .out_ready(arr_wr_ready),
    .out_data(fifo_out)
  );

  assign arr_wr_bank = fifo_out[WW-1 -: 2];
  assign arr_wr_col = fifo_out[DATA_W +: COL_W];
  assign arr_wr_data = fifo_out[DATA_W-1:0];
  assign arr_rd_en = rd_en_q;
  assign arr_rd_bank = rd_bank_q;
  assign arr_rd_col = rd_col_q;
  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign ref_stb = ref_stb_q;
  assign ref_row = ref_row_q;
  assign self_ref = self_ref_q;
  assign power_down = power_down_q;

  AST_REF_ROW_INC: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    is_ref |=> ref_stb_q && (ref_row_q == $past(ref_row_q) + 1'b1))
    else $error("refresh row did not advance by one");
  AST_DESEL_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    (cs_n && !(burst_q && bap_q) && st_q == ST_RUN) |=> $stable(bank_open_q) && !ref_stb_q)
    else $error("deselect changed bank state");
  AST_BST_ENDS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (is_bst && !is_rdwr) |=> !burst_q && !$past(wr_push))
    else $error("burst stop did not end burst");
  AST_RD_DRAIN: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    (is_bst && !bwr_q && cas_lat == CL_3 && $past(rd_en_q) && !dqm) ##1 (cke_q && !dqm && !is_rdwr) [*3]
    |=> !dq_oe_q)
    else $error("read data continued past cas latency");
  AST_SUSP_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
    (!cke_q && st_q == ST_RUN) |=> $stable(bcol_q) && $stable(dq_out_q) && $stable(burst_q))
    else $error("state moved while suspended");
  AST_PDN_FLOAT: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
    pd_enter |=> power_down_q ##1 (!dq_oe_q || !power_down_q))
    else $error("buffers active in power-down");
  AST_PDN_EXIT: assert property (@(posedge mclk) disable iff (!rst_n) // RULE19
    (st_q == ST_PDN && cke) |=> st_q == ST_RUN && !power_down_q)
    else $error("power-down exit missed");
  AST_SELF_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    is_sre |=> self_ref_q && ref_stb_q)
    else $error("self refresh not entered");
  AST_SELF_STAY: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    (st_q == ST_SELF && !cke) |=> st_q == ST_SELF && !dq_oe_q)
    else $error("self refresh left without enable");
  AST_WR_MASK: assert property (@(posedge mclk) disable iff (!rst_n) // RULE20
    ((is_wr || (advance && bwr_q)) && dqm) |-> !wr_push)
    else $error("masked word was written");
  AST_RESUME: assert property (@(posedge mclk) disable iff (!rst_n) // RULE18
    (st_q == ST_RUN && !cke_q && cke && burst_q && !bfull_q && bleft_q > 10'h001)
    ##1 (cs_n || cmd == CMD_NOP) |=> bleft_q != $past(bleft_q))
    else $error("burst did not restart after enable high");
endmodule // srp_sdram_cmd

//--- testbench/srp_bank_model.sv
// bank array stand-in: address-coded read data, stallable write port
`timescale 1ns/1ps
module srp_bank_model (
  // read port
  input wire logic arr_rd_en,
  input wire logic [1:0] arr_rd_bank,
  input wire logic [8:0] arr_rd_col,
  output logic [15:0] arr_rd_data,
  // write port
  input wire logic stall,
  output logic arr_wr_ready
);
  logic [15:0] pat;
  assign pat = {5'h15, arr_rd_bank, arr_rd_col};
  // word only while fetched, inverted otherwise
  assign arr_rd_data = arr_rd_en ? pat : ~pat;
  assign arr_wr_ready = ~stall;
endmodule // srp_bank_model

//--- testbench/tb_top.sv
// self-checking bench for the refresh and power command block
`timescale 1ns/1ps
module tb_top;
  import srp_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic ras_n = 1'b1;
  logic cas_n = 1'b1;
  logic we_n = 1'b1;
  logic cke = 1'b1;
  logic dqm = 1'b0;
  logic stall = 1'b0;
  logic [1:0] ba = 2'h1;
  logic [12:0] addr = 13'h0000;
  logic [15:0] dq_in = 16'h0000;
  logic [2:0] cas_lat = CL_2;
  logic [2:0] burst_len = BL_8;
  logic [15:0] dq_out, arr_rd_data, arr_wr_data;
  logic [8:0] arr_rd_col, arr_wr_col;
  logic [1:0] arr_rd_bank, arr_wr_bank;
  logic [12:0] ref_row;
  logic dq_oe, arr_rd_en, arr_wr_valid, arr_wr_ready, ref_stb, wbuf_ready, self_ref, power_down;
  logic ck1 = 1'b1;
  logic ck2 = 1'b1;
  int miscompares = 0;
  int n_checks = 0;
  int n_ref = 0;
  logic [15:0] q_rd[$];
  logic [26:0] q_wr[$];

  srp_sdram_cmd srp_sdram_cmd_inst (.mclk, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .cke, .dqm,
    .ba, .addr, .dq_in, .dq_out, .dq_oe, .cas_lat, .burst_len, .arr_rd_en, .arr_rd_bank,
    .arr_rd_col, .arr_rd_data, .arr_wr_valid, .arr_wr_ready, .arr_wr_bank, .arr_wr_col,
    .arr_wr_data, .ref_stb, .ref_row, .wbuf_ready, .self_ref, .power_down);
  srp_bank_model srp_bank_model_inst (.arr_rd_en, .arr_rd_bank, .arr_rd_col, .arr_rd_data,
    .stall, .arr_wr_ready);

  always #20 mclk = ~mclk;

  // refresh pulses, fresh read words, written words
  always @(posedge mclk) begin
    if (ref_stb === 1'b1) n_ref++;
    if (dq_oe === 1'b1 && ck2 === 1'b1) q_rd.push_back(dq_out);
    if (arr_wr_valid === 1'b1 && arr_wr_ready === 1'b1) begin
      q_wr.push_back({arr_wr_bank, arr_wr_col, arr_wr_data});
    end
    ck2 = ck1;
    ck1 = cke;
  end

  task chk_flag(logic got, logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_val(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task cyc(logic cs, logic [2:0] c, logic k, logic [12:0] a, logic m, logic [15:0] d);
    @(posedge mclk);
    cs_n <= cs;
    {ras_n, cas_n, we_n} <= c;
    cke <= k;
    addr <= a;
    dqm <= m;
    dq_in <= d;
  endtask

  task cmd(logic [2:0] c, logic k);
    cyc(1'b0, c, k, 13'h0000, 1'b0, 16'h0000);
  endtask

  task nop(int n);
    repeat (n) cmd(CMD_NOP, 1'b1);
  endtask

  task t_refresh;
    int n0;
    n0 = n_ref;
    cyc(1'b0, CMD_REF, 1'b1, 13'h1fff, 1'b0, 16'h0000);
    cmd(CMD_REF, 1'b1);
    cmd(CMD_REF, 1'b1);
    nop(1);
    cyc(1'b1, CMD_REF, 1'b1, 13'h0000, 1'b0, 16'h0000);
    nop(4);
    @(negedge mclk);
    chk_val(n_ref - n0, 2);
    chk_val({19'h0, ref_row}, n_ref);
  endtask

  task t_selfref;
    int n0;
    n0 = n_ref;
    cmd(CMD_REF, 1'b0);
    repeat (100) cmd(CMD_ACT, 1'b0);
    @(negedge mclk);
    chk_flag(self_ref, 1'b1);
    chk_val(n_ref - n0, 1);
    cmd(CMD_NOP, 1'b1);
    cmd(CMD_REF, 1'b1);
    nop(3);
    cmd(CMD_REF, 1'b1);
    nop(3);
    @(negedge mclk);
    chk_flag(self_ref, 1'b0);
    chk_val(n_ref - n0, 2);
    chk_val({19'h0, ref_row}, n_ref);
  endtask

  task t_pdown;
    int n0;
    n0 = n_ref;
    repeat (3) cmd(CMD_NOP, 1'b0);
    @(negedge mclk);
    chk_flag(power_down, 1'b1);
    cmd(CMD_NOP, 1'b1);
    cmd(CMD_REF, 1'b1);
    nop(3);
    @(negedge mclk);
    chk_flag(power_down, 1'b0);
    chk_val(n_ref - n0, 1);
  endtask

  task run_read(logic [2:0] cl, logic ap, int stp, int msk, int sus, int exp);
    logic [2:0] c;
    int k;
    q_rd.delete();
    @(posedge mclk);
    cas_lat <= cl;
    burst_len <= BL_8;
    cmd(CMD_ACT, 1'b1);
    for (int i = 0; i < 16; i++) begin
      c = (i == 0) ? CMD_READ : ((i == stp) ? CMD_BST : CMD_NOP);
      cyc(1'b0, c, !(sus >= 0 && (i == sus || i == sus + 1)), {2'h0, ap, 10'h004}, i == msk, 16'h0000);
    end
    cyc(1'b0, CMD_PRE, 1'b1, 13'h0400, 1'b0, 16'h0000);
    @(negedge mclk);
    chk_val(q_rd.size(), exp);
    for (int i = 0; i < exp; i++) begin
      k = i + (msk >= 0 && i >= msk - int'(cl));
      chk_val(q_rd[i], {5'h15, 2'h1, 9'((4 + k) % 8)});
    end
  endtask

  task run_write(logic [2:0] bl, int stp, int msk, int exp);
    logic [2:0] c;
    int w;
    q_wr.delete();
    @(posedge mclk);
    stall <= 1'b1;
    burst_len <= bl;
    cmd(CMD_ACT, 1'b1);
    for (int i = 0; i < 12; i++) begin
      c = (i == 0) ? CMD_WRITE : ((i == stp) ? CMD_BST : CMD_NOP);
      cyc(1'b0, c, 1'b1, 13'h0000, i == msk, 16'ha000 + 16'(i));
    end
    @(negedge mclk);
    chk_flag(wbuf_ready, exp < 8);
    chk_val(q_wr.size(), 0);
    @(posedge mclk);
    stall <= 1'b0;
    cyc(1'b0, CMD_PRE, 1'b1, 13'h0400, 1'b0, 16'h0000);
    nop(12);
    @(negedge mclk);
    chk_val(q_wr.size(), exp);
    chk_flag(arr_wr_valid, 1'b0);
    for (int j = 0; j < exp; j++) begin
      w = j + (msk >= 0 && j >= msk);
      chk_val(q_wr[j], {5'h00, 2'h1, 9'(w), 16'ha000 + 16'(w)});
    end
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    nop(2);
    @(negedge mclk);
    chk_flag(dq_oe, 1'b0);
    chk_flag(self_ref, 1'b0);
    chk_flag(power_down, 1'b0);
    chk_flag(wbuf_ready, 1'b1);
    chk_val({19'h0, ref_row}, 0);
    t_refresh;
    t_selfref;
    t_pdown;
    run_read(CL_2, 1'b0, 3, -1, -1, 3);
    run_read(CL_3, 1'b0, 3, -1, -1, 3);
    run_read(CL_3, 1'b1, 3, 4, -1, 7);
    run_read(CL_2, 1'b0, -1, -1, 5, 8);
    run_write(BL_8, 3, 1, 2);
    run_write(BL_FULL, 10, -1, 8);
    report_and_stop;
  end

  initial begin
    #(MCLK_PERIOD_NS * 5000);
    miscompares++;
    report_and_stop;
  end
endmodule // tb_top
